// >>> design/gpp_port.sv
`timescale 1ns/1ns
module gpp_port #(parameter int NUM_LINES = gpp_pkg::LINES_DEF) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [gpp_pkg::BUS_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [gpp_pkg::BUS_W-1:0] hwdata,
   output logic [gpp_pkg::BUS_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pads
   input wire logic [NUM_LINES-1:0] pad_in,
   output logic [NUM_LINES-1:0] pad_out,
   output logic [NUM_LINES-1:0] pad_oe_n,
   output logic [NUM_LINES-1:0] pad_pull_en,
   output logic [NUM_LINES-1:0] pad_rx_en
);
   import gpp_pkg::*;

   typedef logic [NUM_LINES-1:0] gpp_lines_type;

   // ************************************************************
   // address phase decode
   // ************************************************************
   logic addr_phase;
   logic addr_hit;
   logic wr_req;
   logic rd_req;
   logic [OFS_W-1:0] addr_ofs;

   // only whole-word transfers are expected, so hsize is not decoded
   assign addr_phase = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
   assign addr_hit = (haddr[BUS_W-1:OFS_W] == '0);
   assign addr_ofs = haddr[OFS_W-1:0];
   assign wr_req = addr_phase && hwrite && addr_hit;
   assign rd_req = addr_phase && !hwrite;

   // ************************************************************
   // data phase state
   // ************************************************************
   logic wr_pend_reg;
   logic [OFS_W-1:0] wr_ofs_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_reg <= 1'h0;
         wr_ofs_reg <= '0;
      end else begin
         wr_pend_reg <= wr_req;
         wr_ofs_reg <= addr_ofs;
      end
   end

   logic sel_den;
   logic sel_pull;
   logic sel_rx;
   logic sel_lvl;
   logic sel_high;
   logic sel_low;
   logic sel_flip;
   logic sel_strobe;
   gpp_lines_type wdata_lines;

   assign sel_den = wr_pend_reg && (wr_ofs_reg == OFS_DRIVE_EN);
   assign sel_pull = wr_pend_reg && (wr_ofs_reg == OFS_PULL_EN);
   assign sel_rx = wr_pend_reg && (wr_ofs_reg == OFS_RX_EN);
   assign sel_lvl = wr_pend_reg && (wr_ofs_reg == OFS_DRIVE_LVL);
   assign sel_high = wr_pend_reg && (wr_ofs_reg == OFS_DRV_HIGH);
   assign sel_low = wr_pend_reg && (wr_ofs_reg == OFS_DRV_LOW);
   assign sel_flip = wr_pend_reg && (wr_ofs_reg == OFS_FLIP);
   assign sel_strobe = sel_high || sel_low || sel_flip;
   assign wdata_lines = hwdata[NUM_LINES-1:0];

   // ************************************************************
   // control registers
   // ************************************************************
   gpp_lines_type drive_enable_reg;
   gpp_lines_type drive_enable_next;
   gpp_lines_type pull_enable_reg;
   gpp_lines_type pull_enable_next;
   gpp_lines_type rx_path_enable_reg;
   gpp_lines_type rx_path_enable_next;
   gpp_lines_type drive_level_reg;
   gpp_lines_type drive_level_next;
   gpp_lines_type pad_oe_n_reg;

   assign drive_enable_next = sel_den ? wdata_lines : drive_enable_reg;
   assign pull_enable_next = sel_pull ? wdata_lines : pull_enable_reg;
   assign rx_path_enable_next = sel_rx ? wdata_lines : rx_path_enable_reg;

   // strobes act on the stored level, so a later read shows the outcome
   assign drive_level_next = sel_lvl ? wdata_lines :
      sel_high ? (drive_level_reg | wdata_lines) :
      sel_low ? (drive_level_reg & ~wdata_lines) :
      sel_flip ? (drive_level_reg ^ wdata_lines) :
      drive_level_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_enable_reg <= NUM_LINES'(REG_RESET);
         pull_enable_reg <= NUM_LINES'(REG_RESET);
         rx_path_enable_reg <= NUM_LINES'(REG_RESET);
         drive_level_reg <= NUM_LINES'(REG_RESET);
         pad_oe_n_reg <= ~NUM_LINES'(REG_RESET);
      end else begin
         drive_enable_reg <= drive_enable_next;
         pull_enable_reg <= pull_enable_next;
         rx_path_enable_reg <= rx_path_enable_next;
         drive_level_reg <= drive_level_next;
         pad_oe_n_reg <= ~drive_enable_next;
      end
   end

   // ************************************************************
   // input stage
   // ************************************************************
   gpp_in_if #(.W(NUM_LINES)) in_io ();

   // the raw pad goes straight to the stage, which synchronises it first
   assign in_io.pin_raw = pad_in;
   assign in_io.rx_en = rx_path_enable_reg;

   gpp_in_stage #(.W(NUM_LINES)) u_in_stage (
      .clk(clk),
      .rst(rst),
      .io(in_io)
   );

   // ************************************************************
   // read path
   // ************************************************************
   gpp_lines_type rd_lines;
   logic [BUS_W-1:0] rd_word;

   // read mux looks at next values: a read right behind a write sees it
   assign rd_lines = !addr_hit ? '0 :
      (addr_ofs == OFS_DRIVE_EN) ? drive_enable_next :
      (addr_ofs == OFS_PULL_EN) ? pull_enable_next :
      (addr_ofs == OFS_RX_EN) ? rx_path_enable_next :
      (addr_ofs == OFS_LEVEL_RD) ? in_io.level :
      (addr_ofs == OFS_DRIVE_LVL) ? drive_level_next :
      '0;
   assign rd_word = BUS_W'(rd_lines);

   logic [BUS_W-1:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_reg <= '0;
         hreadyout_reg <= HREADY_IDLE;
         hresp_reg <= HRESP_OKAY;
      end else begin
         hrdata_reg <= rd_req ? rd_word : '0;
         hreadyout_reg <= HREADY_IDLE;
         hresp_reg <= HRESP_OKAY;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign pad_out = drive_level_reg;
   assign pad_oe_n = pad_oe_n_reg;
   assign pad_pull_en = pull_enable_reg;
   assign pad_rx_en = rx_path_enable_reg;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_wr(logic [OFS_W-1:0] ofs);
      wr_pend_reg && (wr_ofs_reg == ofs);
   endsequence

   sequence s_rd(logic [OFS_W-1:0] ofs);
      rd_req && addr_hit && (addr_ofs == ofs);
   endsequence

   property p_drive_en;
      s_wr(OFS_DRIVE_EN) |=> pad_oe_n == ~$past(hwdata[NUM_LINES-1:0]) ##1 $stable(pad_oe_n)
         or s_wr(OFS_DRIVE_EN);
   endproperty
   a_drive_en: assert property (p_drive_en) else $error("drive enable not applied");

   property p_pull;
      s_wr(OFS_PULL_EN) |=> pad_pull_en == $past(hwdata[NUM_LINES-1:0]);
   endproperty
   a_pull: assert property (p_pull) else $error("pull enable not applied");

   property p_rx;
      s_wr(OFS_RX_EN) |=> pad_rx_en == $past(hwdata[NUM_LINES-1:0]);
   endproperty
   a_rx: assert property (p_rx) else $error("receive enable not applied");

   property p_level_write;
      s_wr(OFS_DRIVE_LVL) |=> pad_out == $past(hwdata[NUM_LINES-1:0]);
   endproperty
   a_level_write: assert property (p_level_write) else $error("drive level not applied");

   property p_high;
      s_wr(OFS_DRV_HIGH) |=> pad_out == ($past(pad_out) | $past(hwdata[NUM_LINES-1:0]));
   endproperty
   a_high: assert property (p_high) else $error("drive-high strobe wrong");

   property p_low;
      s_wr(OFS_DRV_LOW) |=> pad_out == ($past(pad_out) & ~$past(hwdata[NUM_LINES-1:0]));
   endproperty
   a_low: assert property (p_low) else $error("drive-low strobe wrong");

   property p_flip;
      s_wr(OFS_FLIP) |=> pad_out == ($past(pad_out) ^ $past(hwdata[NUM_LINES-1:0]));
   endproperty
   a_flip: assert property (p_flip) else $error("flip strobe wrong");

   property p_zero_bits;
      sel_strobe |=> (pad_out & ~$past(hwdata[NUM_LINES-1:0]))
         == ($past(pad_out) & ~$past(hwdata[NUM_LINES-1:0]));
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("zero strobe bit changed level");

   property p_reset_state;
      $past(rst) |-> pad_out == '0 && pad_oe_n == '1 && pad_pull_en == '0
         && pad_rx_en == '0 && hrdata == '0;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("outputs not at reset state");

   property p_strobe_read;
      (s_rd(OFS_DRV_HIGH) or s_rd(OFS_DRV_LOW) or s_rd(OFS_FLIP)) |=> hrdata == '0;
   endproperty
   a_strobe_read: assert property (p_strobe_read) else $error("strobe read not zero");

   property p_level_readback;
      s_wr(OFS_FLIP) ##1 s_rd(OFS_DRIVE_LVL) |=> hrdata == BUS_W'(pad_out);
   endproperty
   a_level_readback: assert property (p_level_readback) else $error("readback stale");
endmodule

// >>> design/gpp_pkg.sv
package gpp_pkg;
   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int BUS_W = 32;
   localparam int OFS_W = 8;
   localparam int REG_W = 16;
   localparam int LINES_DEF = 8;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [OFS_W-1:0] OFS_DRIVE_EN = 8'h04;
   localparam logic [OFS_W-1:0] OFS_PULL_EN = 8'h08;
   localparam logic [OFS_W-1:0] OFS_RX_EN = 8'h0c;
   localparam logic [OFS_W-1:0] OFS_LEVEL_RD = 8'h10;
   localparam logic [OFS_W-1:0] OFS_DRIVE_LVL = 8'h14;
   localparam logic [OFS_W-1:0] OFS_DRV_HIGH = 8'h18;
   localparam logic [OFS_W-1:0] OFS_DRV_LOW = 8'h1c;
   localparam logic [OFS_W-1:0] OFS_FLIP = 8'h20;

   // ************************************************************
   // reset values and bus codes
   // ************************************************************
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic HREADY_IDLE = 1'h1;
endpackage

// >>> design/gpp_in_if.sv
`timescale 1ns/1ns
interface gpp_in_if #(parameter int W = gpp_pkg::LINES_DEF);
   logic [W-1:0] pin_raw;
   logic [W-1:0] rx_en;
   logic [W-1:0] level;
   modport stage (input pin_raw, input rx_en, output level);
   modport ctrl (output pin_raw, output rx_en, input level);
endinterface

// >>> design/gpp_in_stage.sv
`timescale 1ns/1ns
module gpp_in_stage #(parameter int W = gpp_pkg::LINES_DEF) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin side and level result
   gpp_in_if.stage io
);
   import gpp_pkg::*;

   // ************************************************************
   // synchroniser and gated level register
   // ************************************************************
   logic [W-1:0] sync1_reg;
   logic [W-1:0] sync2_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] level_next;

   // disabled receive path reads zero whatever the pin does
   assign level_next = sync2_reg & io.rx_en;
   assign io.level = level_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         level_reg <= '0;
      end else begin
         sync1_reg <= io.pin_raw;
         sync2_reg <= sync1_reg;
         level_reg <= level_next;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_steady;
      ($stable(io.pin_raw) && $stable(io.rx_en))[*4];
   endsequence

   property p_level_follows;
      s_steady |-> io.level == (io.pin_raw & io.rx_en);
   endproperty
   a_level_follows: assert property (p_level_follows) else $error("level not pin state");

   property p_level_off;
      (io.rx_en == '0)[*2] |-> io.level == '0;
   endproperty
   a_level_off: assert property (p_level_off) else $error("level nonzero with rx off");
endmodule

// >>> sim/gpp_pin_model.sv
`timescale 1ns/1ns
module gpp_pin_model #(parameter int W = 8) (
   // clock
   input wire logic clk,
   // device pads
   input wire logic [W-1:0] pad_out,
   input wire logic [W-1:0] pad_oe_n,
   input wire logic [W-1:0] pad_pull_en,
   // outside drivers set by the bench
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   input wire logic pull_level,
   // level at the pins
   output logic [W-1:0] pad_in
);
   logic [W-1:0] float_reg = '0;
   // a loose line wanders, so a stale level never passes for a read
   always @(posedge clk) float_reg <= ~float_reg;
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pad_pull_en[i]) pad_in[i] = pull_level;
         else pad_in[i] = float_reg[i];
      end
   end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import gpp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [BUS_W-1:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [BUS_W-1:0] hwdata = '0;
   logic [BUS_W-1:0] hrdata;
   logic hreadyout, hresp;
   logic [7:0] pad_in, pad_out, pad_oe_n, pad_pull_en, pad_rx_en;
   logic [7:0] ext_en = '0;
   logic [7:0] ext_val = '0;
   logic [7:0] seed = 8'h0e;
   logic [7:0] lvl, d, p, r, v;
   logic [7:0] sa [3] = '{OFS_DRV_HIGH, OFS_DRV_LOW, OFS_FLIP};
   int n_fail = 0;
   int cmp_count = 0;
   always #5 clk = ~clk;
   gpp_port #(.NUM_LINES(8)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en), .pad_rx_en(pad_rx_en));
   gpp_pin_model #(.W(8)) pins (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pull_en(pad_pull_en), .ext_en(ext_en), .ext_val(ext_val), .pull_level(1'b1),
      .pad_in(pad_in));
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] strobe_exp(input int k, input logic [7:0] o, m);
      return (k == 0) ? (o | m) : (k == 1) ? (o & ~m) : (o ^ m);
   endfunction
   function automatic logic [7:0] pin_exp(input logic [7:0] dd, o, e, ev, pp);
      return (dd & o) | (~dd & e & ev) | (~dd & ~e & pp);
   endfunction
   task automatic chk_reg(input logic [BUS_W-1:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected reg at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [BUS_W-1:0] a, input logic w, input logic [7:0] wd,
                      output logic [BUS_W-1:0] rd);
      // callers return on an edge; the data phase drives htrans idle, so back-to-back transfers follow without a gap but never overlap
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [BUS_W-1:0] a, input logic [7:0] wd);
      logic [BUS_W-1:0] x;
      bus(a, 1'b1, wd, x);
   endtask
   task automatic rd_chk(input logic [BUS_W-1:0] a, input logic [7:0] exp);
      logic [BUS_W-1:0] x;
      bus(a, 1'b0, 8'h00, x);
      chk_reg(x, {24'h0, exp});
      chk_reg({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask
   // registered pad outputs land on the edge that ends the write's data phase
   task automatic settle();
      @(posedge clk);
      #1;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk_pin(pad_oe_n, 8'hff);
      chk_pin(pad_out | pad_pull_en | pad_rx_en, 8'h00);
      for (int a = 0; a <= 'h24; a += 4) rd_chk(a, 8'h00);
      rd_chk(32'h104, 8'h00);
      lvl = 8'h00;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed); d = seed;
         seed = lfsr(seed); p = seed;
         seed = lfsr(seed); r = seed;
         seed = lfsr(seed); lvl = seed;
         wr(OFS_DRIVE_EN, d);
         wr(OFS_PULL_EN, p);
         wr(OFS_RX_EN, r);
         wr(OFS_DRIVE_LVL, lvl);
         settle();
         chk_pin(pad_oe_n, ~d);
         chk_pin(pad_pull_en, p);
         chk_pin(pad_rx_en, r);
         chk_pin(pad_out, lvl);
         rd_chk(OFS_DRIVE_EN, d);
         rd_chk(OFS_PULL_EN, p);
         rd_chk(OFS_RX_EN, r);
      end
      // the first three passes write all-zero strobes, which must change nothing
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         v = (i < 3) ? 8'h00 : seed;
         wr(sa[i % 3], v);
         lvl = strobe_exp(i % 3, lvl, v);
         // read right behind the strobe write: it must already see the result
         rd_chk(OFS_DRIVE_LVL, lvl);
         settle();
         chk_pin(pad_out, lvl);
         rd_chk(sa[i % 3], 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed); d = (i == 0) ? 8'h00 : seed;
         seed = lfsr(seed); p = seed;
         seed = lfsr(seed); r = (i == 1) ? 8'hff : seed;
         seed = lfsr(seed); ext_val <= seed;
         ext_en <= ~p;
         wr(OFS_DRIVE_EN, d);
         wr(OFS_PULL_EN, p);
         wr(OFS_RX_EN, r);
         wr(OFS_LEVEL_RD, 8'hff);
         repeat (4) @(posedge clk);
         rd_chk(OFS_LEVEL_RD, r & pin_exp(d, lvl, ~p, ext_val, p));
      end
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_pin(pad_oe_n, 8'hff);
      chk_pin(pad_out | pad_pull_en | pad_rx_en, 8'h00);
      rst <= 1'b0;
      rd_chk(OFS_DRIVE_EN, 8'h00);
      rd_chk(OFS_DRIVE_LVL, 8'h00);
      rd_chk(OFS_RX_EN, 8'h00);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done();
   end
endmodule
